// File: design/supply_seq_consts.svh
/*
 * Named constants of the supply, reset and gate-drive lockout sequencer.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef SUPPLY_SEQ_CONSTS_SVH
`define SUPPLY_SEQ_CONSTS_SVH

`define SETPOINT_W 4
`define UV_THR_W 3
`define SYNC_W 6
`define UV_THR_OFF 3'h0
`define SETPOINT_RST 4'h0
`define UV_THR_RST 3'h0
`define BLANK_TIME_NS 150000
`define CLK_PERIOD_NS 25
`define SYNC_WAKE_ONE 0
`define SYNC_WAKE_TWO 1
`define SYNC_WAKE_THREE 2
`define SYNC_LOGIC_OK 3
`define SYNC_BATT_OK 4
`define SYNC_GD_LOW 5

`endif

// File: design/supply_seq_pkg.sv
/*
 * Types shared by the sequencer and its bench.
 * Assumes the constants header is on the include path.
 */
`include "supply_seq_consts.svh"

package supply_seq_pkg;

    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_POR_WAIT,
        MODE_BLANK,
        MODE_NORMAL
    } seq_mode_t;

    typedef struct packed {
        logic keep_logic_supply_on;
        logic [`SETPOINT_W-1:0] gate_drive_supply_setpoint;
        logic [`UV_THR_W-1:0] gate_drive_undervolt_threshold;
    } spi_cfg_t;

    typedef struct packed {
        logic logic_regulator_en;
        logic logic_reset_n;
        logic booster_en;
        logic uv_lockout;
        logic uv_blanking;
        logic [`SETPOINT_W-1:0] drive_setpoint;
        logic [`UV_THR_W-1:0] uv_threshold;
    } ctrl_out_t;

endpackage

// File: design/bit_sync.sv
/*
 * Two-flop synchroniser for a group of unrelated asynchronous levels.
 * Assumes each bit is an independent level; no bus coherence is kept.
 */
`timescale 1ns/1ps

module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // Sampling clock
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain
    output logic [WIDTH-1:0] sync_out // Levels safe to use
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // Only the second stage is read, so metastability settles unseen.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_ff <= '0;
            stable_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule

// File: design/supply_enable_and_gate_drive_uvlo.sv
/*
 * Supply enable, chip reset and gate-drive undervoltage lockout control.
 * Assumes core_clk is the internal trimmed RC oscillator, that the wake
 * pins and analog comparator flags are asynchronous, and that the SPI
 * settings and booster request come from logic on core_clk.
 */
`timescale 1ns/1ps
`include "supply_seq_consts.svh"

// Summary of operation
// - The gate-drive target is one of sixteen levels picked by a 4-bit setpoint.
// - A gate-drive supply below the chosen threshold turns the booster off.
// - Undervoltage detection is ignored for 150 us after reset release.
// - The 3-bit threshold field sets the lockout level relative to the setpoint.
// - A threshold field of zero disables the lockout entirely.
// - The logic regulator runs and reset lifts only while a wake input is high or keep-supply-on is set.
// - With keep-supply-on set the chip stays up even with all wake inputs low.
// - With keep-supply-on clear and all wake inputs low the chip resets and powers down.
// - Reset holds at power-up until both logic and battery supplies are valid.
// - Every function and timing runs from the single internal RC clock.
module supply_enable_and_gate_drive_uvlo #(
    parameter int BLANK_CYCLES =
        (`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire logic core_clk, // Internal RC clock
    input wire logic rst_n, // Power-up reset, active low
    input wire logic wake_input_one, // Wake pin one
    input wire logic failsafe_or_wake_input_two, // Wake pin two
    input wire logic wake_input_three, // Wake pin three
    input wire logic logic_supply_valid, // Logic supply monitor flag
    input wire logic battery_supply_valid, // Battery supply monitor flag
    input wire logic gate_drive_below_level, // Gate-drive comparator flag
    input wire logic booster_request, // Booster wants to switch
    input wire supply_seq_pkg::spi_cfg_t spi_cfg, // SPI settings
    output supply_seq_pkg::ctrl_out_t ctrl_out // Supply and reset controls
);
    import supply_seq_pkg::*;

    localparam int CNT_W = $clog2(BLANK_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        seq_mode_t mode;
        logic [CNT_W-1:0] blank_cnt;
        ctrl_out_t out;
    } seq_state_t;

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [`SYNC_W-1:0] raw_in;
    logic [`SYNC_W-1:0] sync_in;
    logic any_wake;
    logic supplies_ok;
    logic stay_on;
    logic uv_enabled;
    seq_state_t state_ff;
    seq_state_t nxt_state;

    // Reset asserts at once but releases on the clock, two edges later.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    always_comb
    begin
        raw_in = '0;
        raw_in[`SYNC_WAKE_ONE] = wake_input_one;
        raw_in[`SYNC_WAKE_TWO] = failsafe_or_wake_input_two;
        raw_in[`SYNC_WAKE_THREE] = wake_input_three;
        raw_in[`SYNC_LOGIC_OK] = logic_supply_valid;
        raw_in[`SYNC_BATT_OK] = battery_supply_valid;
        raw_in[`SYNC_GD_LOW] = gate_drive_below_level;
    end

    bit_sync #(
        .WIDTH(`SYNC_W)
    ) u_pin_sync (
        .clk(core_clk),
        .arst_n(rst_sync_ff),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign any_wake = sync_in[`SYNC_WAKE_ONE] | sync_in[`SYNC_WAKE_TWO]
        | sync_in[`SYNC_WAKE_THREE];
    assign supplies_ok = sync_in[`SYNC_LOGIC_OK]
        & sync_in[`SYNC_BATT_OK];
    assign stay_on = any_wake | spi_cfg.keep_logic_supply_on;
    assign uv_enabled =
        spi_cfg.gate_drive_undervolt_threshold != `UV_THR_OFF;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff.mode)
            MODE_OFF:
            begin
                nxt_state.blank_cnt = CNT_ZERO;
                if (any_wake)
                begin
                    nxt_state.mode = MODE_POR_WAIT;
                end
            end
            MODE_POR_WAIT:
            begin
                // SPI state is in reset here, so keep-supply-on cannot hold.
                nxt_state.blank_cnt = CNT_ZERO;
                if (!any_wake)
                begin
                    nxt_state.mode = MODE_OFF;
                end
                else if (supplies_ok)
                begin
                    nxt_state.mode = MODE_BLANK;
                end
            end
            MODE_BLANK, MODE_NORMAL:
            begin
                if (!stay_on)
                begin
                    nxt_state.mode = MODE_OFF;
                end
                else if (!supplies_ok)
                begin
                    nxt_state.mode = MODE_POR_WAIT;
                end
                else if (state_ff.mode == MODE_BLANK)
                begin
                    if (state_ff.blank_cnt == CNT_LAST)
                    begin
                        nxt_state.mode = MODE_NORMAL;
                    end
                    else
                    begin
                        nxt_state.blank_cnt =
                            state_ff.blank_cnt + CNT_ONE;
                    end
                end
            end
        endcase

        nxt_state.out.logic_regulator_en =
            nxt_state.mode != MODE_OFF;
        nxt_state.out.logic_reset_n = (nxt_state.mode == MODE_BLANK)
            | (nxt_state.mode == MODE_NORMAL);
        nxt_state.out.uv_blanking = nxt_state.mode == MODE_BLANK;

        // Settings read as defaults while the logic is held in reset.
        if (nxt_state.out.logic_reset_n)
        begin
            nxt_state.out.drive_setpoint =
                spi_cfg.gate_drive_supply_setpoint;
            nxt_state.out.uv_threshold =
                spi_cfg.gate_drive_undervolt_threshold;
        end
        else
        begin
            nxt_state.out.drive_setpoint = `SETPOINT_RST;
            nxt_state.out.uv_threshold = `UV_THR_RST;
        end

        // The lockout follows the comparator and releases when it clears.
        nxt_state.out.uv_lockout = (nxt_state.mode == MODE_NORMAL)
            & uv_enabled & sync_in[`SYNC_GD_LOW];
        nxt_state.out.booster_en = nxt_state.out.logic_reset_n
            & booster_request & ~nxt_state.out.uv_lockout;
    end

    always_ff @(posedge core_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            state_ff <= '{mode: MODE_OFF, blank_cnt: CNT_ZERO, out: '0};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign ctrl_out = state_ff.out;
endmodule

// File: bench/host_model.sv
/*
 * Host stand-in driving the wake pins and the SPI settings.
 * Assumes the bench sets wanted levels at the clock edge.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk, // Clock
    input wire logic [2:0] want_wake, // Wanted pin levels
    input wire supply_seq_pkg::spi_cfg_t want_cfg, // Wanted settings
    output logic [2:0] wake, // Wake pins
    output supply_seq_pkg::spi_cfg_t cfg // Settings
);
    import supply_seq_pkg::*;
    always_ff @(posedge core_clk)
    begin
        wake <= want_wake;
        cfg <= want_cfg;
    end
endmodule

// File: bench/supply_seq_properties.sv
/*
 * Timing checks of the sequencer outputs.
 * Assumes it is bound to the top with BLANK_CYCLES handed on.
 */
`timescale 1ns/1ps
module supply_seq_checker #(
    parameter int BLANK_CYCLES = 6000
) (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic wake_input_one, // Wake pin one
    input wire logic failsafe_or_wake_input_two, // Wake pin two
    input wire logic wake_input_three, // Wake pin three
    input wire logic booster_request, // Booster request
    input wire supply_seq_pkg::spi_cfg_t spi_cfg, // Settings
    input wire supply_seq_pkg::ctrl_out_t ctrl_out // Controls
);
    import supply_seq_pkg::*;
    logic any_wake;
    int blank_cnt;
    assign any_wake = wake_input_one | failsafe_or_wake_input_two
        | wake_input_three;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            blank_cnt <= 0;
        else
            blank_cnt <= ctrl_out.uv_blanking ? blank_cnt + 1 : 0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_thr_zero: assert property (
        ctrl_out.uv_threshold == 3'h0 |-> !ctrl_out.uv_lockout)
        else $error("lockout with zero code");
    chk_blank_quiet: assert property (
        ctrl_out.uv_blanking |-> !ctrl_out.uv_lockout)
        else $error("lockout in blanking");
    chk_blank_len: assert property (
        $fell(ctrl_out.uv_blanking) && ctrl_out.logic_reset_n
        |-> blank_cnt == BLANK_CYCLES) else $error("blanking length");
    chk_lock_boost: assert property (
        ctrl_out.uv_lockout |-> !ctrl_out.booster_en)
        else $error("booster on in lockout");
    chk_boost_cause: assert property (
        ctrl_out.booster_en |-> $past(booster_request)
        && ctrl_out.logic_reset_n) else $error("booster unrequested");
    chk_reg_first: assert property (
        ctrl_out.logic_reset_n |-> ctrl_out.logic_regulator_en)
        else $error("awake without regulator");
    chk_keep_on: assert property (
        ctrl_out.logic_reset_n && spi_cfg.keep_logic_supply_on
        |=> ctrl_out.logic_regulator_en) else $error("keep-on lost");
    chk_sleep: assert property (
        (!any_wake && !spi_cfg.keep_logic_supply_on) [*4]
        |=> !ctrl_out.logic_regulator_en) else $error("no sleep");
    chk_codes: assert property (
        ctrl_out.logic_reset_n |-> ctrl_out.drive_setpoint ==
        $past(spi_cfg.gate_drive_supply_setpoint) && ctrl_out.uv_threshold
        == $past(spi_cfg.gate_drive_undervolt_threshold))
        else $error("codes not passed");
    cov_blank_end: cover property ($fell(ctrl_out.uv_blanking));
    cov_lockout: cover property (ctrl_out.uv_lockout);
    cov_kept: cover property (ctrl_out.logic_reset_n && !any_wake);
endmodule

bind supply_enable_and_gate_drive_uvlo supply_seq_checker #(
    .BLANK_CYCLES(BLANK_CYCLES)
) i_supply_seq_checker (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wake_input_one(wake_input_one),
    .failsafe_or_wake_input_two(failsafe_or_wake_input_two),
    .wake_input_three(wake_input_three),
    .booster_request(booster_request),
    .spi_cfg(spi_cfg),
    .ctrl_out(ctrl_out)
);

// File: bench/supply_enable_and_gate_drive_uvlo_bench.sv
/*
 * Self-checking bench of the sequencer.
 * Assumes the checker is bound in and the host model drives the pins.
 */
`timescale 1ns/1ps
module supply_enable_and_gate_drive_uvlo_bench;
    import supply_seq_pkg::*;
    localparam int BLANK = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic logic_ok = 1'b0;
    logic batt_ok = 1'b0;
    logic gd_low = 1'b0;
    logic boost_req = 1'b0;
    logic [2:0] want_wake = 3'h0;
    spi_cfg_t want_cfg = '0;
    logic [2:0] wake;
    spi_cfg_t cfg;
    ctrl_out_t ctrl;
    logic [31:0] seed = 32'h2d19fa82;
    logic [2:0] thr;
    logic [1:0] e_lock;
    int failures = 0;
    int comparisons = 0;
    always #12.5 core_clk = ~core_clk;
    host_model i_host_model (
        .core_clk(core_clk),
        .want_wake(want_wake),
        .want_cfg(want_cfg),
        .wake(wake),
        .cfg(cfg)
    );
    supply_enable_and_gate_drive_uvlo #(
        .BLANK_CYCLES(BLANK)
    ) i_supply_enable_and_gate_drive_uvlo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wake_input_one(wake[0]),
        .failsafe_or_wake_input_two(wake[1]),
        .wake_input_three(wake[2]),
        .logic_supply_valid(logic_ok),
        .battery_supply_valid(batt_ok),
        .gate_drive_below_level(gd_low),
        .booster_request(boost_req),
        .spi_cfg(cfg),
        .ctrl_out(ctrl)
    );
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [1:0] lock_exp(input logic g, input logic r,
        input logic [2:0] t);
        lock_exp[1] = g && t != 3'h0;
        lock_exp[0] = r && !lock_exp[1];
    endfunction
    function automatic logic [3:0] st();
        return {ctrl.logic_regulator_en, ctrl.logic_reset_n,
            ctrl.uv_blanking, ctrl.uv_lockout};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] want);
        comparisons++;
        if (got !== want)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        tick(5);
        rst_n <= 1'b1;
        tick(8);
        check(st(), 4'h0);
        want_wake <= 3'h1;
        tick(6);
        check(st(), 4'h8);
        logic_ok <= 1'b1;
        tick(6);
        check(st(), 4'h8);
        batt_ok <= 1'b1;
        gd_low <= 1'b1;
        boost_req <= 1'b1;
        want_cfg <= '{1'b0, 4'h9, 3'h5};
        tick(6);
        check(st(), 4'he);
        tick(BLANK);
        check(st(), 4'hd);
        check({ctrl.booster_en, ctrl.uv_threshold}, 4'h5);
        $display("power-up test done");
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            thr = (i == 0) ? 3'h0 : seed[2:0];
            want_cfg <= '{1'b0, i[3:0], thr};
            gd_low <= seed[8] | (i == 0);
            boost_req <= seed[9];
            tick(5);
            e_lock = lock_exp(gd_low, boost_req, thr);
            check(ctrl.drive_setpoint, i[3:0]);
            check({ctrl.booster_en, ctrl.uv_threshold}, {e_lock[0], thr});
            check(st(), {3'h6, e_lock[1]});
        end
        $display("code test done");
        want_cfg <= '{1'b1, 4'h3, 3'h0};
        want_wake <= 3'h0;
        tick(8);
        check(st(), 4'hc);
        want_cfg <= '{1'b0, 4'h3, 3'h0};
        tick(4);
        check(st(), 4'h0);
        $display("keep-on test done");
        for (int i = 1; i < 3; i++)
        begin
            want_wake <= 3'(1 << i);
            tick(7);
            check(st(), 4'he);
            want_wake <= 3'h0;
            tick(6);
            check(st(), 4'h0);
        end
        $display("wake pin test done");
        want_wake <= 3'h1;
        tick(BLANK + 8);
        check(st(), 4'hc);
        logic_ok <= 1'b0;
        tick(5);
        check(st(), 4'h8);
        check(ctrl.drive_setpoint, 4'h0);
        logic_ok <= 1'b1;
        tick(5);
        check(st(), 4'he);
        rst_n <= 1'b0;
        tick(5);
        check(st(), 4'h0);
        rst_n <= 1'b1;
        tick(3);
        check(st(), 4'h0);
        tick(BLANK + 8);
        check(st(), 4'hc);
        $display("supply loss and reset test done");
        finish_test();
    end
endmodule
